// ===== hw/reset_clock_source_config_pkg.sv
// Constants, register map and mode encoding for the reset-time clock source configuration block
package reset_clock_source_config_pkg;

   // ----------------------------------------------------------------
   // Bus geometry
   // ----------------------------------------------------------------
   localparam int          ADDR_W      = 12;             // Byte address width of the slave
   localparam int          ROM_WORDS   = 256;            // Sixteen-bit boot ROM words
   localparam int          ROM_BYTES   = 512;            // Boot ROM size in bytes
   localparam logic [1:0]  RESP_OKAY   = 2'h0;           // Normal completion
   localparam logic [1:0]  RESP_SLVERR = 2'h2;           // Denied or unmapped access

   // ----------------------------------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [11:0] OFS_ROM_LAST = 12'h1fc;       // Last word of the boot ROM window
   localparam logic [11:0] OFS_STATUS   = 12'h200;       // Latched reset configuration
   localparam logic [11:0] OFS_SYNTH    = 12'h204;       // Synth_control_reg reset image
   localparam logic [11:0] OFS_INTEG    = 12'h208;       // Integration_config_reg ROM bits

   // ----------------------------------------------------------------
   // Port_clock_shadow bit positions
   // ----------------------------------------------------------------
   localparam int SH_SPEED = 0;                          // Reference_speed_select
   localparam int SH_CLKPIN = 1;                         // Clkpin_default
   localparam int SH_DOUBLE = 2;                         // Double_rate_default
   localparam int SH_FCODE = 3;                          // Function_code_pin_default
   localparam int SH_ACK = 4;                            // Ack_pin_default

   // ----------------------------------------------------------------
   // Integration_config_reg field positions and reset value
   // ----------------------------------------------------------------
   localparam int         IC_ROM_EN   = 0;               // Rom_enable_bit
   localparam int         IC_ROM_SUPV = 1;               // Rom_supervisor_only
   localparam logic [1:0] INTEG_RESET = 2'h3;            // ROM on, supervisor only

   // ----------------------------------------------------------------
   // Synthesizer field reset values
   // ----------------------------------------------------------------
   localparam logic       X_HALF      = 1'h1;            // Half-rate bit set
   localparam logic       X_FULL      = 1'h0;            // Half-rate bit clear
   localparam logic [2:0] W_ZERO      = 3'h0;            // Multiplier cleared
   localparam logic [2:0] W_DOUBLE    = 3'h3;            // Fast mode twice reference
   localparam logic [5:0] Y_ZERO      = 6'h00;           // No prescale
   localparam logic [5:0] Y_SLOW      = 6'h3f;           // Slow mode count 63

   // ----------------------------------------------------------------
   // Clock modes
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      MODE_EXT  = 3'b001,                                // External clock, synthesizer off
      MODE_FAST = 3'b010,                                // Fast reference PLL
      MODE_SLOW = 3'b100                                 // Slow reference PLL
   } mode_t;

endpackage

// ===== hw/reset_clock_source_config.sv
// Reset-time clock source selection, pin default loading and guarded boot ROM behind AXI4-Lite
//
// Added by the designer: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps

// How it works
// - Shadow bit four sets port D4 default
// - Shadow bit three picks function code pins
// - Shadow bit two picks 1x/2x fast clock
// - Low config pin: aux interrupt picks 1x/2x
// - Shadow bit one sets port E4 default
// - Supply high: bit zero picks fast/slow
// - Supply low forces external clock mode
// - Low config pin: freeze pin picks fast/slow
// - 512-byte boot ROM, 256 sixteen-bit words
// - ROM gated by enable and supervisor bits
// - Supply low disables synthesizer entirely
// - External mode: PLL off, X=1, Y=0
// - Fast mode fields reset per double bit
// - Slow mode resets X=0, W=0, Y=63
// - PLL clock has fifty percent duty
// - Contents survive clock rate changes
// - Defaults load from shadow during reset
module reset_clock_source_config #(
   parameter logic [15:0] SHADOW_MASK = 16'h0000,        // Mask-programmed shadow, arbitrary value
   parameter logic [15:0] ROM_FILL    = 16'hffff         // Generic boot ROM fill
) (
   input  wire logic        clk,                         // 25 MHz system clock
   input  wire logic        nrst,                        // Asynchronous reset, active low
   input  wire logic        drive_config_n,              // Drive_config_pin, low selects pin override
   input  wire logic        synth_supply_pin,            // High: synthesizer powered
   input  wire logic        aux_interrupt_pin,           // Override level for double rate
   input  wire logic        debug_freeze_pin,            // Override level for reference speed
   input  wire logic [11:0] awaddr,
   input  wire logic [2:0]  awprot,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [11:0] araddr,
   input  wire logic [2:0]  arprot,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   output logic [2:0]       clock_mode,                  // One-hot mode chosen at reset
   output logic             pll_enable,                  // Synthesizer running
   output logic             synth_x,                     // Half-rate bit reset value
   output logic [2:0]       synth_w,                     // Multiplier reset value
   output logic [5:0]       synth_y,                     // Prescale or count reset value
   output logic             port_d4_assign_bit,          // 1: transfer_acknowledge, 0: port_d_bit4
   output logic [7:4]       port_e_assign_reg,           // [7:5] cycle_function_code, [4] clock output
   output logic             config_loaded                // Reset configuration captured
);
   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic        in_reset;                                // High until the first edge after release
   logic        next_slow;                               // Reference speed after override
   logic        next_double;                             // Double rate after override
   logic [2:0]  next_mode;                               // Mode to latch
   logic        next_x;                                  // Field values to latch
   logic [2:0]  next_w;
   logic [5:0]  next_y;
   logic [1:0]  integ;                                   // Integration_config_reg ROM bits
   logic        aw_got;                                  // Write address held
   logic        w_got;                                   // Write data held
   logic [11:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0]  w_strb_q;
   logic        do_write;                                // Both halves present this cycle
   logic        integ_hit;                               // Write hits the integration register
   logic [31:0] rd_data;
   logic [1:0]  rd_resp;
   logic [31:0] status_word;
   logic [31:0] synth_word;
   logic        rom_hit;
   logic        rom_allowed;
   logic [15:0] rom_mem [0:255];                         // Mask ROM image
   // ----------------------------------------------------------------
   // Reset window
   // ----------------------------------------------------------------
   // Stays high through the first edge after release so that edge samples the pins
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         in_reset <= 1'b1;
      end else begin
         in_reset <= 1'b0;
      end
   end
   // ----------------------------------------------------------------
   // Source and field selection
   // ----------------------------------------------------------------
   // Pins only override the two clock bits; port defaults always come from the shadow
   always_comb begin
      next_slow   = drive_config_n ? SHADOW_MASK[reset_clock_source_config_pkg::SH_SPEED]
                                   : debug_freeze_pin;
      next_double = drive_config_n ? SHADOW_MASK[reset_clock_source_config_pkg::SH_DOUBLE]
                                   : aux_interrupt_pin;
      if (!synth_supply_pin) begin
         next_mode = reset_clock_source_config_pkg::MODE_EXT;
      end else if (next_slow) begin
         next_mode = reset_clock_source_config_pkg::MODE_SLOW;
      end else begin
         next_mode = reset_clock_source_config_pkg::MODE_FAST;
      end
   end
   // Reset values of the synthesizer fields per mode
   always_comb begin
      case (next_mode)
         reset_clock_source_config_pkg::MODE_FAST: begin
            // Twice reference when double rate is set
            next_x = next_double ? reset_clock_source_config_pkg::X_FULL
                                 : reset_clock_source_config_pkg::X_HALF;
            next_w = next_double ? reset_clock_source_config_pkg::W_DOUBLE
                                 : reset_clock_source_config_pkg::W_ZERO;
            next_y = reset_clock_source_config_pkg::Y_ZERO;
         end
         reset_clock_source_config_pkg::MODE_SLOW: begin
            next_x = reset_clock_source_config_pkg::X_FULL;
            next_w = reset_clock_source_config_pkg::W_ZERO;
            next_y = reset_clock_source_config_pkg::Y_SLOW;
         end
         default: begin
            // External clock passes straight through with no divider
            next_x = reset_clock_source_config_pkg::X_HALF;
            next_w = reset_clock_source_config_pkg::W_ZERO;
            next_y = reset_clock_source_config_pkg::Y_ZERO;
         end
      endcase
   end
   // ----------------------------------------------------------------
   // Configuration latch
   // ----------------------------------------------------------------
   // Loaded only in the reset window; afterwards no pin can disturb it. The latched
   // state is static, so nothing here depends on the clock rate.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         clock_mode         <= reset_clock_source_config_pkg::MODE_EXT;
         pll_enable         <= 1'b0;
         synth_x            <= reset_clock_source_config_pkg::X_HALF;
         synth_w            <= reset_clock_source_config_pkg::W_ZERO;
         synth_y            <= reset_clock_source_config_pkg::Y_ZERO;
         port_d4_assign_bit <= 1'b0;
         port_e_assign_reg  <= 4'h0;
         config_loaded      <= 1'b0;
      end else if (in_reset) begin
         clock_mode         <= next_mode;
         // PLL output is divided from the VCO, giving even duty whatever the reference
         pll_enable         <= synth_supply_pin;
         synth_x            <= next_x;
         synth_w            <= next_w;
         synth_y            <= next_y;
         port_d4_assign_bit <= SHADOW_MASK[reset_clock_source_config_pkg::SH_ACK];
         port_e_assign_reg  <= {{3{SHADOW_MASK[reset_clock_source_config_pkg::SH_FCODE]}},
                                SHADOW_MASK[reset_clock_source_config_pkg::SH_CLKPIN]};
         config_loaded      <= 1'b1;
      end
   end
   // ----------------------------------------------------------------
   // Boot ROM image
   // ----------------------------------------------------------------
   // Generic parts carry a uniform fill; a custom image would replace this constant
   generate
      for (genvar gi = 0; gi < reset_clock_source_config_pkg::ROM_WORDS; gi++) begin : g_rom
         assign rom_mem[gi] = ROM_FILL;
      end
   endgenerate
   // ----------------------------------------------------------------
   // Write channel
   // ----------------------------------------------------------------
   assign do_write  = aw_got && w_got && !bvalid;
   assign integ_hit = aw_addr_q == reset_clock_source_config_pkg::OFS_INTEG;
   // Address and data are taken in either order; response follows both
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         awready   <= 1'b0;
         wready    <= 1'b0;
         aw_got    <= 1'b0;
         w_got     <= 1'b0;
         aw_addr_q <= 12'h000;
         w_data_q  <= 32'h0000_0000;
         w_strb_q  <= 4'h0;
         bvalid    <= 1'b0;
         bresp     <= reset_clock_source_config_pkg::RESP_OKAY;
      end else begin
         // Address half
         if (awvalid && awready) begin
            awready   <= 1'b0;
            aw_got    <= 1'b1;
            aw_addr_q <= awaddr;
         end else if (!aw_got && !bvalid) begin
            awready <= 1'b1;
         end
         // Data half
         if (wvalid && wready) begin
            wready   <= 1'b0;
            w_got    <= 1'b1;
            w_data_q <= wdata;
            w_strb_q <= wstrb;
         end else if (!w_got && !bvalid) begin
            wready <= 1'b1;
         end
         // Response
         if (do_write) begin
            aw_got <= 1'b0;
            w_got  <= 1'b0;
            bvalid <= 1'b1;
            // Read-only registers accept and ignore; ROM and holes are errors
            if (integ_hit || aw_addr_q == reset_clock_source_config_pkg::OFS_STATUS
                          || aw_addr_q == reset_clock_source_config_pkg::OFS_SYNTH) begin
               bresp <= reset_clock_source_config_pkg::RESP_OKAY;
            end else begin
               bresp <= reset_clock_source_config_pkg::RESP_SLVERR;
            end
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end
   // Integration register: the only software-writable state
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         integ <= reset_clock_source_config_pkg::INTEG_RESET;
      end else if (do_write && integ_hit && w_strb_q[0]) begin
         integ <= w_data_q[1:0];
      end
   end
   // ----------------------------------------------------------------
   // Read decode
   // ----------------------------------------------------------------
   assign status_word = {20'h00000, config_loaded, clock_mode == reset_clock_source_config_pkg::MODE_SLOW,
                         synth_w != 3'h0 && clock_mode == reset_clock_source_config_pkg::MODE_FAST,
                         port_e_assign_reg, port_d4_assign_bit, pll_enable, clock_mode};
   assign rom_hit     = araddr <= reset_clock_source_config_pkg::OFS_ROM_LAST;
   // Supervisor-only ROM needs a privileged access
   assign rom_allowed = integ[reset_clock_source_config_pkg::IC_ROM_EN] &&
                        (!integ[reset_clock_source_config_pkg::IC_ROM_SUPV] || arprot[0]);
   // Synth register image laid out per mode
   always_comb begin
      case (clock_mode)
         reset_clock_source_config_pkg::MODE_SLOW: begin
            synth_word = {16'h0000, synth_x, synth_w[0], synth_y, 8'h00};
         end
         reset_clock_source_config_pkg::MODE_FAST: begin
            synth_word = {16'h0000, synth_x, synth_w, 1'b0, synth_y[2:0], 8'h00};
         end
         default: begin
            synth_word = {16'h0000, synth_x, 4'h0, synth_y[2:0], 8'h00};
         end
      endcase
   end
   // Word read returns two ROM halfwords; byte lanes are picked by the master
   always_comb begin
      rd_data = 32'h0000_0000;
      rd_resp = reset_clock_source_config_pkg::RESP_OKAY;
      if (rom_hit) begin
         if (rom_allowed) begin
            rd_data = {rom_mem[{araddr[8:2], 1'b1}], rom_mem[{araddr[8:2], 1'b0}]};
         end else begin
            rd_resp = reset_clock_source_config_pkg::RESP_SLVERR;
         end
      end else if (araddr == reset_clock_source_config_pkg::OFS_STATUS) begin
         rd_data = status_word;
      end else if (araddr == reset_clock_source_config_pkg::OFS_SYNTH) begin
         rd_data = synth_word;
      end else if (araddr == reset_clock_source_config_pkg::OFS_INTEG) begin
         rd_data = {30'h00000000, integ};
      end else begin
         rd_resp = reset_clock_source_config_pkg::RESP_SLVERR;
      end
   end
   // ----------------------------------------------------------------
   // Read channel
   // ----------------------------------------------------------------
   // One read in flight; the answer is registered at the same edge that takes the address
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= 32'h0000_0000;
         rresp   <= reset_clock_source_config_pkg::RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rdata   <= rd_data;
         rresp   <= rd_resp;
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
      end else if (!rvalid) begin
         arready <= 1'b1;
      end
   end
   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // Sampled nrst is still low at the release edge, so only the latching edge starts these
   a_ext_no_supply: assert property (nrst && in_reset && !synth_supply_pin |=>
      clock_mode == reset_clock_source_config_pkg::MODE_EXT && !pll_enable) else $error("supply low not external");
   a_shadow_speed: assert property (nrst && in_reset && synth_supply_pin && drive_config_n |=>
      clock_mode == (SHADOW_MASK[0] ? 3'b100 : 3'b010)) else $error("shadow speed not applied");
   a_freeze_override: assert property (nrst && in_reset && synth_supply_pin && !drive_config_n |=>
      clock_mode == ($past(debug_freeze_pin) ? 3'b100 : 3'b010)) else $error("freeze override lost");
   a_irq_override: assert property (nrst && in_reset && synth_supply_pin && !drive_config_n &&
      !debug_freeze_pin |=> synth_w == ($past(aux_interrupt_pin) ? 3'h3 : 3'h0))
      else $error("double rate override lost");
   a_fast_fields: assert property (clock_mode == 3'b010 |-> synth_y == 6'h00 &&
      ((synth_x && synth_w == 3'h0) || (!synth_x && synth_w == 3'h3))) else $error("fast fields wrong");
   a_slow_fields: assert property (clock_mode == 3'b100 |->
      !synth_x && synth_w == 3'h0 && synth_y == 6'h3f) else $error("slow fields wrong");
   a_ext_fields: assert property (clock_mode == 3'b001 && config_loaded |->
      synth_x && synth_y == 6'h00 && !pll_enable) else $error("external fields wrong");
   a_pin_defaults: assert property (config_loaded |-> port_d4_assign_bit == SHADOW_MASK[4] &&
      port_e_assign_reg == {{3{SHADOW_MASK[3]}}, SHADOW_MASK[1]}) else $error("port defaults wrong");
   a_config_frozen: assert property (!in_reset |=> $stable(clock_mode) && $stable(synth_y) &&
      $stable(port_e_assign_reg) && config_loaded) else $error("configuration moved");
   a_rom_denied: assert property (arvalid && arready && rom_hit && !integ[0] |=>
      rvalid && rresp == 2'h2 && rdata == 32'h0) else $error("disabled ROM answered");
   a_rom_read: assert property (arvalid && arready && rom_hit && integ[0] && (!integ[1] || arprot[0]) |=>
      rvalid && rresp == 2'h0 && rdata == {ROM_FILL, ROM_FILL}) else $error("ROM read wrong");
   a_resp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped");
   c_slow_mode: cover property (config_loaded && clock_mode == 3'b100);
   c_ext_mode: cover property (config_loaded && clock_mode == 3'b001);
   c_rom_read: cover property (rvalid && rready && rresp == 2'h0);
   c_integ_write: cover property (do_write && integ_hit);
endmodule

// ===== verification/ref_source_model.sv
// Reference source and configuration pin model facing the clock configuration block
`timescale 1ns/1ps
module ref_source_model #(
   parameter real SLOW_HALF_NS = 15259.0,       // About 32.8 kHz reference
   parameter real FAST_HALF_NS = 125.0          // 4 MHz reference
) (
   input  wire logic [3:0] req,                 // Plan: config pin, supply, aux, freeze
   output logic            drive_config_n,      // Low lets the pins below override
   output logic            synth_supply_pin,    // Low means we supply the clock
   output logic            aux_interrupt_pin,   // Double rate override level
   output logic            debug_freeze_pin,    // Slow/fast override level
   output logic            oscillator_input     // Reference, runs free
);
   // ----------
   // Pin levels
   // ----------
   // Held as long as the plan stands, so reset sampling never sees a glitch
   assign {drive_config_n, synth_supply_pin, aux_interrupt_pin, debug_freeze_pin} = req;
   // Rate follows the freeze level; both stay inside their allowed bands
   initial begin
      oscillator_input = 1'b0;
      forever #(debug_freeze_pin ? SLOW_HALF_NS : FAST_HALF_NS) oscillator_input = ~oscillator_input;
   end
endmodule

// ===== verification/test_reset_clock_source_config.sv
// Self-checking bench for the reset clock source configuration block
`timescale 1ns/1ps
module test_reset_clock_source_config;
   // ----------
   // Signals
   // ----------
   logic        clk = 1'b0;                     // 25 MHz
   logic        nrst = 1'b0;                    // Active low
   logic [3:0]  req = 4'hf;                     // Pin plan for the partner
   logic        dcn, sup, aux, frz, osc;
   logic [11:0] awaddr = 12'h0, araddr = 12'h0;
   logic [2:0]  awprot = 3'h0, arprot = 3'h0;
   logic [31:0] wdata = 32'h0;
   logic [3:0]  wstrb = 4'hf;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, pll_enable, synth_x, port_d4_assign_bit, config_loaded;
   logic [1:0]  bresp, rresp, resp;
   logic [31:0] rdata, got;
   logic [2:0]  clock_mode, synth_w;
   logic [5:0]  synth_y;
   logic [3:0]  port_e_assign_reg;
   int          error_cnt = 0, n_checks = 0, i;
   // Shadow 1d: ack 1, function code 1, double 1, clock pin 0, slow 1
   logic [17:0] cfg [6] = '{{4'hc, 3'h4, 1'b1, 1'b0, 3'h0, 6'h3f}, {4'h8, 3'h1, 1'b0, 1'b1, 3'h0, 6'h00},
                            {4'h4, 3'h2, 1'b1, 1'b1, 3'h0, 6'h00}, {4'h6, 3'h2, 1'b1, 1'b0, 3'h3, 6'h00},
                            {4'h7, 3'h4, 1'b1, 1'b0, 3'h0, 6'h3f}, {4'h3, 3'h1, 1'b0, 1'b1, 3'h0, 6'h00}};
   // Bus rows: write, address, prot, data, response, read data
   logic [81:0] ops [12] = '{{1'b0, 12'h208, 3'h1, 32'h0, 2'h0, 32'h3}, {1'b0, 12'h200, 3'h1, 32'h0, 2'h0, 32'h9d1},
                             {1'b0, 12'h204, 3'h1, 32'h0, 2'h0, 32'h8000}, {1'b0, 12'h1fc, 3'h1, 32'h0, 2'h0, ~32'h0},
                             {1'b0, 12'h000, 3'h0, 32'h0, 2'h2, 32'h0}, {1'b1, 12'h000, 3'h0, 32'h5, 2'h2, 32'h0},
                             {1'b1, 12'h208, 3'h0, 32'h1, 2'h0, 32'h0}, {1'b0, 12'h000, 3'h0, 32'h0, 2'h0, ~32'h0},
                             {1'b1, 12'h208, 3'h0, 32'h0, 2'h0, 32'h0}, {1'b0, 12'h004, 3'h1, 32'h0, 2'h2, 32'h0},
                             {1'b0, 12'h20c, 3'h1, 32'h0, 2'h2, 32'h0}, {1'b0, 12'h208, 3'h1, 32'h0, 2'h0, 32'h0}};
   wire  [13:0] cfg_out = {clock_mode, pll_enable, synth_x, synth_w, synth_y};
   wire  [5:0]  pin_out = {port_d4_assign_bit, port_e_assign_reg, config_loaded};
   always #20 clk = ~clk;
   // ----------
   // Instances
   // ----------
   ref_source_model src (.req(req), .drive_config_n(dcn), .synth_supply_pin(sup), .aux_interrupt_pin(aux),
                         .debug_freeze_pin(frz), .oscillator_input(osc));
   reset_clock_source_config #(.SHADOW_MASK(16'h001d), .ROM_FILL(16'hffff)) uut (.clk(clk), .nrst(nrst),
      .drive_config_n(dcn), .synth_supply_pin(sup), .aux_interrupt_pin(aux), .debug_freeze_pin(frz),
      .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arprot(arprot), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .clock_mode(clock_mode), .pll_enable(pll_enable), .synth_x(synth_x), .synth_w(synth_w),
      .synth_y(synth_y), .port_d4_assign_bit(port_d4_assign_bit), .port_e_assign_reg(port_e_assign_reg),
      .config_loaded(config_loaded));
   // ----------
   // Tasks
   // ----------
   task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task end_of_test();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // Pins are planned before reset and held past the first edge after release
   task do_reset(input logic [3:0] r);
      @(posedge clk);
      nrst <= 1'b0;
      req <= r;
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
   endtask
   // One transfer; each valid drops at the edge its ready is seen, ready waits for the answer
   task xfer(input logic w, input logic [11:0] a, input logic [2:0] p, input logic [31:0] d);
      int k;
      @(posedge clk);
      {awaddr, wdata, awvalid, wvalid, bready} <= w ? {a, d, 3'h7} : {awaddr, wdata, 3'h0};
      {araddr, arprot, arvalid, rready} <= w ? {araddr, arprot, 2'h0} : {a, p, 2'h3};
      for (k = 0; k < 40; k++) begin
         @(posedge clk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         if (arready === 1'b1) arvalid <= 1'b0;
         if ((w ? bvalid : rvalid) === 1'b1) break;
      end
      resp = w ? bresp : rresp;
      got = rdata;
      {bready, rready} <= 2'h0;
      // Released lines must not keep showing the old value
      {awaddr, wdata, araddr} <= ~{awaddr, wdata, araddr};
      if (k == 40) begin
         cmp("bus answer", 32'h1, 32'h0);
         end_of_test();
      end
   endtask
   // ----------
   // Sequence
   // ----------
   initial begin
      for (i = 0; i < 6; i++) begin
         do_reset(cfg[i][17:14]);
         cmp("clock cfg", 32'(cfg[i][13:0]), 32'(cfg_out));
         cmp("pin cfg", 32'h3d, 32'(pin_out));
         req <= ~cfg[i][17:14];
         repeat (3) @(posedge clk);
         cmp("held cfg", 32'(cfg[i][13:0]), 32'(cfg_out));
         $display("test config row %0d done", i);
      end
      for (i = 0; i < 12; i++) begin
         xfer(ops[i][81], ops[i][80:69], ops[i][68:66], ops[i][65:34]);
         cmp("bus resp", 32'(ops[i][33:32]), 32'(resp));
         if (ops[i][81] == 1'b0) cmp("bus rdata", ops[i][31:0], got);
      end
      $display("test bus map done");
      // Mid-run reset must return every latched output and both answers to reset values
      nrst <= 1'b0;
      @(posedge clk);
      cmp("reset cfg", 32'h0000_0a00, 32'(cfg_out));
      cmp("reset pins", 32'h0000_0000, 32'({pin_out, bvalid, rvalid}));
      $display("test reset values done");
      end_of_test();
   end
endmodule
